/* hdl/adr_ctrl.sv */
`timescale 1ns/1ns
module adr_ctrl #(
   parameter int PWRUP_CYC = adr_pkg::T_PWRUP_CYC,
   parameter int REF_INT_CYC = adr_pkg::T_REF_INT_CYC
) (
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic req_valid,
   output logic req_ready,
   input wire logic req_write,
   input wire logic [adr_pkg::ADDR_BITS-1:0] req_addr,
   input wire logic [adr_pkg::DQ_BITS-1:0] req_wdata,
   output logic rsp_valid,
   output logic [adr_pkg::DQ_BITS-1:0] rsp_rdata,
   output logic init_done,
   output logic ras_n,
   output logic cas_n,
   output logic we_n,
   output logic oe_n,
   output logic [adr_pkg::ROW_BITS-1:0] mux_address_pins,
   input wire logic [adr_pkg::DQ_BITS-1:0] data_pins_i,
   output logic [adr_pkg::DQ_BITS-1:0] data_pins_o,
   output logic data_pins_oe
);
   import adr_pkg::*;
   adr_state_t state_r, state_nxt;
   logic [CNT_BITS-1:0] cnt_r, cnt_nxt;
   logic [3:0] init_rows_r;
   logic init_done_r;
   logic wr_r;
   logic [ADDR_BITS-1:0] addr_r;
   logic [DQ_BITS-1:0] wdata_r, rdata_r;
   logic rsp_r;
   logic ras_r, cas_r, we_r, oe_r, dqoe_r;
   logic [ROW_BITS-1:0] mux_r;
   adr_refresh_if rif ();
   adr_refresh_timer #(.REF_INT_CYC(REF_INT_CYC)) u_timer (
      .clk_sys(clk_sys),
      .srst(srst),
      .rif(rif)
   );
   // ----------------------------------------------------------------
   // request acceptance
   // ----------------------------------------------------------------
   wire cnt_done = (cnt_r == '0);
   wire in_idle = (state_r == ST_IDLE) && init_done_r;
   // refresh wins over a waiting access
   assign rif.ack = in_idle && rif.req;
   assign req_ready = in_idle && !rif.req;
   wire take_req = req_ready && req_valid;
   // requests wait out power-up, so only ones raised after it are timed
   property p_refresh_served;
      @(posedge clk_sys) disable iff (srst || !init_done_r)
         $rose(rif.req) |-> ##[0:30] rif.ack;
   endproperty
   a_refresh_served: assert property (p_refresh_served)
      else $error("refresh request not served in time");
   // ----------------------------------------------------------------
   // sequencer
   // ----------------------------------------------------------------
   // every wait below is a cycle count rounded in the package
   always_comb begin
      state_nxt = state_r;
      cnt_nxt = cnt_done ? cnt_r : cnt_r - 1'b1;
      unique case (state_r)
         ST_INIT_WAIT: if (cnt_done) begin
            state_nxt = ST_INIT_RAS;
            cnt_nxt = CNT_BITS'(T_RAS_MIN_CYC - 1);
         end
         ST_INIT_RAS: if (cnt_done) begin
            state_nxt = ST_PRE;
            cnt_nxt = CNT_BITS'(T_RP_CYC - 1);
         end
         ST_IDLE: begin
            if (!init_done_r) begin
               state_nxt = ST_INIT_RAS;
               cnt_nxt = CNT_BITS'(T_RAS_MIN_CYC - 1);
            end else if (rif.ack) begin
               state_nxt = ST_CBR_CAS;
               cnt_nxt = CNT_BITS'(T_FCS_CYC - 1);
            end else if (take_req) begin
               state_nxt = ST_ROW;
               cnt_nxt = CNT_BITS'(T_RCD_CYC - 1);
            end
         end
         ST_ROW: if (cnt_done) begin
            state_nxt = ST_COL;
            cnt_nxt = CNT_BITS'(T_COL_CYC - 1);
         end
         ST_COL, ST_CBR_RAS: if (cnt_done) begin
            state_nxt = ST_PRE;
            cnt_nxt = CNT_BITS'(T_RP_CYC - 1);
         end
         ST_CBR_CAS: if (cnt_done) begin
            // column strobe already low for the setup time
            state_nxt = ST_CBR_RAS;
            cnt_nxt = CNT_BITS'(T_RAS_MIN_CYC - 1);
         end
         ST_PRE: if (cnt_done) begin
            state_nxt = ST_IDLE;
         end
      endcase
   end
   // ----------------------------------------------------------------
   // pin decode from the next state
   // ----------------------------------------------------------------
   wire ras_nxt = !(state_nxt inside {ST_INIT_RAS, ST_ROW, ST_COL, ST_CBR_RAS});
   // no page mode, one column per row
   wire cas_nxt = !(state_nxt inside {ST_COL, ST_CBR_CAS, ST_CBR_RAS});
   wire access_nxt = state_nxt inside {ST_ROW, ST_COL};
   wire wr_nxt = take_req ? req_write : wr_r;
   // write strobe falls with the row strobe, well before the column strobe
   wire we_nxt = !(access_nxt && wr_nxt);
   // write strobe stays high through a read and its precharge
   // gate low only for a read column phase; writes keep it high
   wire oe_nxt = !((state_nxt == ST_COL) && !wr_nxt);
   wire [ADDR_BITS-1:0] addr_nxt = take_req ? req_addr : addr_r;
   // row half first, column half once the column strobe falls
   wire [ROW_BITS-1:0] mux_nxt =
      (state_nxt == ST_COL) ? addr_nxt[COL_BITS-1:0] :
      (state_nxt == ST_INIT_RAS) ? ROW_BITS'(init_rows_r) : addr_nxt[ADDR_BITS-1:COL_BITS];
   wire sample = (state_r == ST_COL) && cnt_done && !wr_r;
   // ----------------------------------------------------------------
   // state and request registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         state_r <= ST_INIT_WAIT;
         cnt_r <= CNT_BITS'(PWRUP_CYC - 1);
         wr_r <= 1'b0;
         addr_r <= '0;
         wdata_r <= '0;
      end else begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         wr_r <= wr_nxt;
         addr_r <= addr_nxt;
         wdata_r <= take_req ? req_wdata : wdata_r;
      end
   end
   // count eight row-only cycles, then open for accesses
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         init_rows_r <= '0;
         init_done_r <= 1'b0;
      end else begin
         if (state_r == ST_INIT_RAS && cnt_done)
            init_rows_r <= init_rows_r + 1'b1;
         init_done_r <= init_done_r || (init_rows_r == 4'(INIT_RAS_CYCLES));
      end
   end
   // pins are registered so they change only on clock edges
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         ras_r <= 1'b1;
         cas_r <= 1'b1;
         we_r <= 1'b1;
         oe_r <= 1'b1;
         dqoe_r <= 1'b0;
         mux_r <= '0;
      end else begin
         ras_r <= ras_nxt;
         cas_r <= cas_nxt;
         we_r <= we_nxt;
         oe_r <= oe_nxt;
         dqoe_r <= !we_nxt;
         mux_r <= mux_nxt;
      end
   end
   // sample after row and column access times both elapsed
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         rdata_r <= '0;
         rsp_r <= 1'b0;
      end else begin
         rdata_r <= sample ? data_pins_i : rdata_r;
         rsp_r <= sample;
      end
   end
   assign ras_n = ras_r;
   assign cas_n = cas_r;
   assign we_n = we_r;
   assign oe_n = oe_r;
   assign mux_address_pins = mux_r;
   assign data_pins_o = wdata_r;
   assign data_pins_oe = dqoe_r;
   assign rsp_valid = rsp_r;
   assign rsp_rdata = rdata_r;
   assign init_done = init_done_r;
   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   logic [9:0] ras_low_r;
   logic [3:0] ras_falls_r;
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         ras_low_r <= '0;
         ras_falls_r <= '0;
      end else begin
         ras_low_r <= ras_r ? '0 : ras_low_r + 1'b1;
         if (!init_done_r && !ras_nxt && ras_r)
            ras_falls_r <= ras_falls_r + 1'b1;
      end
   end
   property p_ras_max;
      @(posedge clk_sys) disable iff (srst) ras_low_r < 10'(T_RAS_MAX_CYC);
   endproperty
   a_ras_max: assert property (p_ras_max)
      else $error("row strobe held low too long");
   property p_cbr_setup;
      @(posedge clk_sys) disable iff (srst) $fell(ras_n) && !cas_n |-> $past(!cas_n, 1);
   endproperty
   a_cbr_setup: assert property (p_cbr_setup)
      else $error("column strobe not set up before row strobe");
   property p_early_write;
      @(posedge clk_sys) disable iff (srst)
         $fell(cas_n) && !we_n |-> $past(!we_n) && oe_n && data_pins_oe;
   endproperty
   a_early_write: assert property (p_early_write)
      else $error("write strobe not low before column strobe");
   property p_read_hold;
      @(posedge clk_sys) disable iff (srst) !cas_n && !oe_n |-> we_n ##1 we_n;
   endproperty
   a_read_hold: assert property (p_read_hold)
      else $error("write strobe dropped during read");
   property p_init_seq;
      @(posedge clk_sys) disable iff (srst) $rose(init_done) |-> ras_falls_r == 4'd8;
   endproperty
   a_init_seq: assert property (p_init_seq)
      else $error("wrong number of init row cycles");
   property p_no_cas_init;
      @(posedge clk_sys) disable iff (srst) !init_done |-> cas_n && !req_ready;
   endproperty
   a_no_cas_init: assert property (p_no_cas_init)
      else $error("access before init done");
   property p_precharge;
      @(posedge clk_sys) disable iff (srst) $rose(ras_n) |-> ras_n [*5];
   endproperty
   a_precharge: assert property (p_precharge)
      else $error("row precharge too short");
   property p_row_addr;
      @(posedge clk_sys) disable iff (srst)
         $fell(ras_n) && cas_n && init_done |-> mux_address_pins == addr_r[17:9];
   endproperty
   a_row_addr: assert property (p_row_addr)
      else $error("row address not on pins at row strobe");
   property p_rcd;
      @(posedge clk_sys) disable iff (srst)
         $fell(cas_n) && $past(!ras_n) |-> $past(!ras_n, 2) ##0 mux_address_pins == addr_r[8:0];
   endproperty
   a_rcd: assert property (p_rcd)
      else $error("column strobe too soon after row strobe");
   c_read: cover property (@(posedge clk_sys) disable iff (srst) rsp_valid);
   c_write: cover property (@(posedge clk_sys) disable iff (srst) $fell(cas_n) && !we_n);
   c_cbr: cover property (@(posedge clk_sys) disable iff (srst) $fell(ras_n) && !cas_n);
   c_init: cover property (@(posedge clk_sys) disable iff (srst) $rose(init_done));
endmodule : adr_ctrl

/* hdl/adr_refresh_timer.sv */
`timescale 1ns/1ns
module adr_refresh_timer #(
   parameter int REF_INT_CYC = adr_pkg::T_REF_INT_CYC
) (
   input wire logic clk_sys,
   input wire logic srst,
   adr_refresh_if.timer rif
);
   import adr_pkg::*;
   logic [CNT_BITS-1:0] tmr_r;
   logic pend_r;
   wire tick = (tmr_r == '0);
   // ----------------------------------------------------------------
   // interval counter and sticky request
   // ----------------------------------------------------------------
   // one row per interval; a tick in the ack cycle is kept
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         tmr_r <= '0;
         pend_r <= 1'b0;
      end else begin
         tmr_r <= tick ? CNT_BITS'(REF_INT_CYC - 1) : tmr_r - 1'b1;
         pend_r <= tick | (pend_r & ~rif.ack);
      end
   end
   assign rif.req = pend_r;
   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   property p_tick_sets;
      @(posedge clk_sys) disable iff (srst) tick |=> rif.req;
   endproperty
   a_tick_sets: assert property (p_tick_sets)
      else $error("interval tick lost");
endmodule : adr_refresh_timer

/* shared/adr_pkg.sv */
// Behaviour
// - controller issues 512 refreshes, one per row, every 8 ms.
// - after power-up wait 100 us, then 8 row-strobe cycles before accesses.
// - on reads write strobe stays high past row or column strobe rise.
// - page-mode column cycles spaced at least 100 ns (fast) or 120 ns; controller uses no page mode, one column per row.
// - column-first refresh lowers column strobe 20 ns before row strobe.
// - nine row bits on row strobe fall, then nine column bits on column fall.
package adr_pkg;
   // ----------------------------------------------------------------
   // geometry
   // ----------------------------------------------------------------
   localparam int ROW_BITS = 9;
   localparam int COL_BITS = 9;
   localparam int ADDR_BITS = ROW_BITS + COL_BITS;
   localparam int DQ_BITS = 4;
   localparam int INIT_RAS_CYCLES = 8;
   localparam int REFRESH_ROWS = 512;
   // ----------------------------------------------------------------
   // timing, faster grade, in ns
   // ----------------------------------------------------------------
   localparam int CLK_NS = 20;
   localparam int T_RCD_NS = 25;
   localparam int T_CAC_NS = 50;
   localparam int T_RAS_MIN_NS = 100;
   localparam int T_RAS_MAX_NS = 10000;
   localparam int T_RP_NS = 90;
   localparam int T_FCS_NS = 20;
   localparam int T_PWRUP_NS = 100000;
   localparam int T_REF_PERIOD_NS = 8000000;
   // least times round up, longest times round down
   function automatic int min_cyc(input int ns);
      int c;
      c = (ns + CLK_NS - 1) / CLK_NS;
      return (c < 1) ? 1 : c;
   endfunction : min_cyc
   function automatic int max_cyc(input int ns);
      int c;
      c = ns / CLK_NS;
      return (c < 1) ? 1 : c;
   endfunction : max_cyc
   localparam int T_RCD_CYC = min_cyc(T_RCD_NS);
   localparam int T_CAC_CYC = min_cyc(T_CAC_NS);
   localparam int T_RAS_MIN_CYC = min_cyc(T_RAS_MIN_NS);
   localparam int T_RAS_MAX_CYC = max_cyc(T_RAS_MAX_NS);
   localparam int T_RP_CYC = min_cyc(T_RP_NS);
   localparam int T_FCS_CYC = min_cyc(T_FCS_NS);
   localparam int T_PWRUP_CYC = min_cyc(T_PWRUP_NS);
   localparam int T_REF_INT_CYC = max_cyc(T_REF_PERIOD_NS / REFRESH_ROWS);
   // column phase covers access time plus a sample cycle and row width
   localparam int T_COL_CYC = (T_CAC_CYC + 1 > T_RAS_MIN_CYC - T_RCD_CYC) ?
      T_CAC_CYC + 1 : T_RAS_MIN_CYC - T_RCD_CYC;
   localparam int CNT_BITS = 16;
   typedef enum logic [3:0] {
      ST_INIT_WAIT, ST_INIT_RAS, ST_IDLE, ST_ROW, ST_COL, ST_PRE, ST_CBR_CAS, ST_CBR_RAS
   } adr_state_t;
endpackage : adr_pkg

/* shared/adr_refresh_if.sv */
`timescale 1ns/1ns
// refresh request from the interval timer and its acceptance
interface adr_refresh_if;
   logic req;
   logic ack;
   modport timer (output req, input ack);
   modport ctrl (input req, output ack);
endinterface : adr_refresh_if

/* testbench/adr_dram_model.sv */
`timescale 1ns/1ns
// ----------------------------------------------------------------
// memory device seen through its strobes
// ----------------------------------------------------------------
module adr_dram_model #(
   parameter int ACC_NS = 40
) (
   input wire logic ras_n,
   input wire logic cas_n,
   input wire logic we_n,
   input wire logic oe_n,
   input wire logic [adr_pkg::ROW_BITS-1:0] addr,
   input wire logic [adr_pkg::DQ_BITS-1:0] dq_in,
   output logic [adr_pkg::DQ_BITS-1:0] dq_out,
   output logic dq_drv
);
   import adr_pkg::*;
   logic [3:0] mem [0:262143];
   logic [8:0] row_q = 9'h000;
   logic [8:0] col_q = 9'h000;
   logic [8:0] ref_ctr = 9'h000;
   logic early = 1'b0;
   logic acc_ok = 1'b0;
   logic cbr = 1'b0;
   logic [3:0] last_q = 4'h0;
   int n_cbr = 0;
   int n_row_only = 0;
   wire [3:0] rd_word = mem[{row_q, col_q}];
   always @(negedge ras_n) begin
      if (cas_n === 1'b0) begin
         cbr = 1'b1;
         n_cbr++;
         ref_ctr++;
      end else begin
         cbr = 1'b0;
         n_row_only++;
         // address and strobe leave the controller on one clock edge: take it just after
         #1;
         row_q = addr;
      end
   end
   always @(negedge cas_n) begin
      if (ras_n === 1'b0 && !cbr) begin
         acc_ok = 1'b0;
         early = !we_n;
         acc_ok <= #(ACC_NS) 1'b1;
         #1;
         col_q = addr;
         if (!we_n) mem[{row_q, col_q}] = dq_in;
      end
   end
   always @(negedge we_n) begin
      if (!ras_n && !cas_n && !cbr) mem[{row_q, col_q}] = dq_in;
   end
   assign dq_drv = !ras_n && !cas_n && !oe_n && !early && !cbr && acc_ok;
   // released pins never keep the old word, the simulator would hide a late sample
   assign dq_out = dq_drv ? rd_word : ~last_q;
   always @(negedge dq_drv) last_q = rd_word;
endmodule : adr_dram_model

/* testbench/async_dram_interface_tb_top.sv */
`timescale 1ns/1ns
module async_dram_interface_tb_top;
   import adr_pkg::*;
   localparam int PWRUP = 10;
   localparam int REF_INT = 40;
   logic clk_sys = 1'b0;
   logic srst = 1'b1;
   logic req_valid = 1'b0;
   logic req_write = 1'b0;
   logic [ADDR_BITS-1:0] req_addr = 18'h00000;
   logic [DQ_BITS-1:0] req_wdata = 4'h0;
   logic req_ready, rsp_valid, init_done, ras_n, cas_n, we_n, oe_n, dq_oe, m_drv;
   logic [DQ_BITS-1:0] rsp_rdata, dq_o, m_dq, dq_wire;
   logic [ROW_BITS-1:0] mux_pins;
   int failures = 0;
   int n_compared = 0;
   int cyc = 0;
   logic [17:0] a_tab [6] = '{18'h00000, 18'h3ffff, 18'h00001, 18'h00200, 18'h2aa55, 18'h155aa};
   logic [3:0] d_tab [6] = '{4'h5, 4'ha, 4'h3, 4'hc, 4'hf, 4'h0};
   // ----------------------------------------------------------------
   // clock, shared data wire and the two ends
   // ----------------------------------------------------------------
   initial forever #10 clk_sys = ~clk_sys;
   always @(posedge clk_sys) cyc <= cyc + 1;
   assign dq_wire = dq_oe ? dq_o : m_dq;
   adr_ctrl #(.PWRUP_CYC(PWRUP), .REF_INT_CYC(REF_INT)) i_dut (
      .clk_sys(clk_sys), .srst(srst), .req_valid(req_valid), .req_ready(req_ready),
      .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
      .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .init_done(init_done),
      .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .oe_n(oe_n), .mux_address_pins(mux_pins),
      .data_pins_i(dq_wire), .data_pins_o(dq_o), .data_pins_oe(dq_oe));
   adr_dram_model #(.ACC_NS(40)) i_mdl (.ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
      .oe_n(oe_n), .addr(mux_pins), .dq_in(dq_wire), .dq_out(m_dq), .dq_drv(m_drv));
   // ----------------------------------------------------------------
   // compare, verdict and bounded waits
   // ----------------------------------------------------------------
   task automatic check(input logic [17:0] seen, input logic [17:0] exp);
      n_compared++;
      if (seen !== exp) begin
         failures++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic complete_run();
      $display("compared %0d, mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : complete_run
   // a wait that runs dry counts as a mismatch and ends the run
   task automatic give_up();
      failures++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, 1'b0, 1'b1);
      complete_run();
   endtask : give_up
   // request held from a rising edge up to the edge that takes it
   task automatic do_req(input logic wr, input logic [17:0] a, input logic [3:0] d);
      int n;
      n = 0;
      @(posedge clk_sys);
      req_valid <= 1'b1;
      req_write <= wr;
      req_addr <= a;
      req_wdata <= d;
      do begin
         @(negedge clk_sys);
         n++;
      end while (req_ready !== 1'b1 && n < 400);
      if (req_ready !== 1'b1) give_up();
      @(posedge clk_sys);
      req_valid <= 1'b0;
   endtask : do_req
   task automatic read_word(input logic [17:0] a, input logic [3:0] d);
      int n;
      n = 0;
      do_req(1'b0, a, 4'h0);
      do begin
         @(negedge clk_sys);
         n++;
      end while (rsp_valid !== 1'b1 && n < 40);
      if (rsp_valid !== 1'b1) give_up();
      check(18'(rsp_rdata), 18'(d));
      check({i_mdl.row_q, i_mdl.col_q}, a);
      check(18'({ras_n, cas_n, we_n, oe_n}), 18'h0000f);
   endtask : read_word
   // both ends on the data pins at once is a clash
   always @(negedge clk_sys) begin
      if (srst === 1'b0 && (dq_oe === 1'b1 || m_drv === 1'b1)) begin
         check(18'(dq_oe & m_drv), 18'h0);
      end
   end
   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic sc_init();
      int n;
      n = 0;
      repeat (11) @(posedge clk_sys);
      @(negedge clk_sys);
      check({12'h000, ras_n, cas_n, we_n, oe_n, dq_oe, init_done}, 18'h0003c);
      @(posedge clk_sys);
      srst <= 1'b0;
      do begin
         @(negedge clk_sys);
         n++;
      end while (ras_n === 1'b1 && n < 1000);
      if (ras_n !== 1'b0) give_up();
      check(18'(n >= PWRUP), 18'h1);
      do begin
         @(negedge clk_sys);
         n++;
      end while (init_done !== 1'b1 && n < 2000);
      if (n >= 2000) give_up();
      check(18'(i_mdl.n_row_only), 18'h8);
   endtask : sc_init
   // row-only and column-only neighbours must not alias
   task automatic sc_rw();
      for (int i = 0; i < 6; i++) begin
         do_req(1'b1, a_tab[i], d_tab[i]);
      end
      for (int i = 5; i >= 0; i--) begin
         read_word(a_tab[i], d_tab[i]);
      end
   endtask : sc_rw
   // reads issued back to back across many refresh intervals
   task automatic sc_ref();
      int c0, r0, e, d;
      logic [8:0] k0;
      c0 = cyc;
      r0 = i_mdl.n_cbr;
      k0 = i_mdl.ref_ctr;
      for (int i = 0; i < 36; i++) begin
         read_word(a_tab[i % 6], d_tab[i % 6]);
      end
      e = (cyc - c0) / REF_INT;
      d = i_mdl.n_cbr - r0;
      check(18'(d >= e - 1 && d <= e + 1), 18'h1);
      check(18'(i_mdl.ref_ctr - k0), 18'(d));
   endtask : sc_ref
   task automatic sc_over();
      do_req(1'b1, a_tab[1], 4'h6);
      read_word(a_tab[1], 4'h6);
      read_word(a_tab[0], d_tab[0]);
   endtask : sc_over
   initial begin
      sc_init();
      sc_rw();
      sc_ref();
      sc_over();
      complete_run();
   end
endmodule : async_dram_interface_tb_top
